/* File: core/vcm_slew_core.v */
// Functional notes
// - shift received bytes into 16-bit holding register
// - on STOP after two data bytes copy holding word to control word while power-enable is high
// - reads return holding word, same bit order
// - two bytes MSB first; standby, zero, code, slew
// - sink level linear in ten-bit code
// - power-enable low forces full shutdown
// - standby flag set gives soft power saving
// - step field selects 0,1,2,4 codes per step
// - period field selects 64..512 us
// - fast mode serial clock up to 400 kHz
`include "vcm_defs.vh"
module vcm_slew_core #(
  parameter [6:0] DEV_ADDR = `VCM_ADDR_DEF
) (
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  input  wire        scl_i,
  input  wire        sda_i,
  input  wire        power_enable_pin_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  output reg  [9:0]  dac_code_o,
  output reg         sink_enable_o,
  output reg         hw_power_save_o,
  output reg         soft_standby_o,
  output reg  [15:0] current_control_word_o
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_RD   = 5'h10;

  reg [1:0] rst_sync_q;
  wire      rst_n = rst_sync_q[1];
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // pins are async to sys_clk; an extra stage gives the previous value for edge detect
  reg [2:0] scl_q, sda_q, pe_q;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      pe_q  <= 3'h0;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      pe_q  <= {pe_q[1:0], power_enable_pin_i};
    end
  end
  wire scl = scl_q[1];
  wire sda = sda_q[1];
  wire pwr_en = pe_q[1];
  wire scl_rise = scl & ~scl_q[2];
  wire scl_fall = ~scl & scl_q[2];
  // 40 MHz sampling gives ample margin at 400 kHz fast mode
  wire start_ev = scl & scl_q[2] & ~sda & sda_q[2];
  wire stop_ev  = scl & scl_q[2] & sda & ~sda_q[2];

  reg [4:0]  st_q;
  reg [3:0]  bit_q;
  reg [7:0]  sh_q;
  reg [15:0] hold_q;
  reg        byte_q;
  reg        rd_q;
  reg        ack_drv_q;
  reg        rd_drv_q;
  reg        nack_q;
  reg        wr_full_q;
  reg        commit_q;

  assign sda_oe_o = ack_drv_q | (rd_drv_q & ~sda_o);
  assign sda_o    = ack_drv_q ? 1'b0 : hold_q[`VCM_WORD_W - 1 - {byte_q, 3'h0} - bit_q[2:0]];

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      hold_q    <= `VCM_WORD_RST;
      byte_q    <= 1'b0;
      rd_q      <= 1'b0;
      ack_drv_q <= 1'b0;
      rd_drv_q  <= 1'b0;
      nack_q    <= 1'b0;
      wr_full_q <= 1'b0;
      commit_q  <= 1'b0;
    end else begin
      commit_q <= 1'b0;
      if (start_ev) begin
        st_q      <= ST_ADDR;
        bit_q     <= 4'h0;
        byte_q    <= 1'b0;
        wr_full_q <= 1'b0;
        ack_drv_q <= 1'b0;
        rd_drv_q  <= 1'b0;
      end else if (stop_ev) begin
        st_q      <= ST_IDLE;
        ack_drv_q <= 1'b0;
        rd_drv_q  <= 1'b0;
        commit_q  <= wr_full_q;
        wr_full_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            st_q <= ST_IDLE;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                rd_q      <= sh_q[0];
                ack_drv_q <= 1'b1;
                st_q      <= ST_ACK;
              end else begin
                st_q <= ST_IDLE;
              end
              bit_q <= 4'h0;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              ack_drv_q <= 1'b0;
              bit_q     <= 4'h0;
              if (rd_q) begin
                rd_drv_q <= 1'b1;
                st_q     <= ST_RD;
              end else begin
                st_q <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            // bits gather in the byte shifter: the clock rise of a STOP must not disturb the held word
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              hold_q    <= {hold_q[7:0], sh_q};
              bit_q     <= 4'h0;
              ack_drv_q <= 1'b1;
              st_q      <= ST_ACK;
              if (byte_q) wr_full_q <= 1'b1;
              byte_q <= ~byte_q;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              nack_q <= sda;
            end
            if (scl_fall) begin
              if (bit_q[2:0] == `VCM_LAST_BIT) begin
                rd_drv_q <= 1'b0; // release for master ack
                bit_q    <= 4'h8;
              end else if (bit_q == 4'h8) begin
                if (nack_q) begin
                  st_q <= ST_IDLE;
                end else begin
                  byte_q   <= ~byte_q;
                  bit_q    <= 4'h0;
                  rd_drv_q <= 1'b1;
                end
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // step period timebase: 64 us base tick then divide
  reg [`VCM_TICK_W-1:0] tick_q;
  reg [`VCM_DIV_W-1:0]  div_q;
  wire base_tick = (tick_q == `VCM_BASE_CYC - 1);
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= {`VCM_TICK_W{1'b0}};
      div_q  <= {`VCM_DIV_W{1'b0}};
    end else if (commit_q) begin
      tick_q <= {`VCM_TICK_W{1'b0}};
      div_q  <= {`VCM_DIV_W{1'b0}};
    end else if (base_tick) begin
      tick_q <= {`VCM_TICK_W{1'b0}};
      div_q  <= div_q + 4'h1;
    end else begin
      tick_q <= tick_q + 12'h001;
    end
  end

  wire [1:0] per_sel  = current_control_word_o[`VCM_PER_HI:`VCM_PER_LO];
  wire [1:0] step_sel = current_control_word_o[`VCM_STEP_HI:`VCM_STEP_LO];
  wire [3:0] per_mask = (4'h1 << per_sel) - 4'h1;
  wire       step_ev  = base_tick && ((div_q & per_mask) == per_mask);
  wire [9:0] step_sz  = (step_sel == 2'h3) ? 10'h004 : {8'h00, step_sel};
  wire [9:0] target   = current_control_word_o[`VCM_CODE_HI:`VCM_CODE_LO];
  wire [9:0] diff_up  = target - dac_code_o;
  wire [9:0] diff_dn  = dac_code_o - target;

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      current_control_word_o <= `VCM_WORD_RST;
      dac_code_o             <= 10'h000;
      sink_enable_o          <= 1'b0;
      hw_power_save_o        <= 1'b1;
      soft_standby_o         <= 1'b0;
    end else begin
      hw_power_save_o <= ~pwr_en;
      soft_standby_o  <= pwr_en & current_control_word_o[`VCM_BIT_STBY];
      sink_enable_o   <= pwr_en & ~current_control_word_o[`VCM_BIT_STBY];
      if (!pwr_en) begin
        dac_code_o <= 10'h000;
      end else if (commit_q) begin
        current_control_word_o <= hold_q;
        if (hold_q[`VCM_STEP_HI:`VCM_STEP_LO] == 2'h0)
          dac_code_o <= hold_q[`VCM_CODE_HI:`VCM_CODE_LO];
      end else if (step_sel == 2'h0) begin
        dac_code_o <= target;
      end else if (step_ev && target != dac_code_o) begin
        if (target > dac_code_o)
          dac_code_o <= (diff_up < step_sz) ? target : dac_code_o + step_sz;
        else
          dac_code_o <= (diff_dn < step_sz) ? target : dac_code_o - step_sz;
      end
    end
  end
endmodule // vcm_slew_core

/* File: core/vcm_defs.vh */
`ifndef VCM_DEFS_VH
`define VCM_DEFS_VH
`define VCM_WORD_W        16
`define VCM_CODE_W        10
`define VCM_BIT_STBY      15
`define VCM_BIT_ZERO      14
`define VCM_CODE_HI       13
`define VCM_CODE_LO       4
`define VCM_STEP_HI       3
`define VCM_STEP_LO       2
`define VCM_PER_HI        1
`define VCM_PER_LO        0
`define VCM_WORD_RST      16'h0000
`define VCM_ADDR_DEF      7'h0C
`define VCM_CLK_MHZ       40
`define VCM_BASE_US       64
`define VCM_BASE_CYC      (`VCM_BASE_US * `VCM_CLK_MHZ)
`define VCM_TICK_W        12
`define VCM_DIV_W         4
`define VCM_BIT_CNT_W     4
`define VCM_LAST_BIT      4'h7
`endif

/* File: tb/vcm_slew_properties.sv */
module vcm_slew_props (
  input wire logic        sys_clk_i, rstn_i, scl_i, sda_i, power_enable_pin_i, sda_o, sda_oe_o,
  input wire logic        sink_enable_o, hw_power_save_o, soft_standby_o,
  input wire logic [9:0]  dac_code_o,
  input wire logic [15:0] current_control_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] gap, w, pw, n;
  logic [9:0]  t, pd, dif;
  logic        ph, sl;
  assign w = current_control_word_o;
  assign t = w[13:4];
  assign n = 16'h0A00 << w[1:0];
  assign dif = (dac_code_o > pd) ? dac_code_o - pd : pd - dac_code_o;
  assign sl = w == pw && w[3:2] != 2'h0 && dac_code_o != pd && !hw_power_save_o && !ph;
  // first step is timed from the commit, so a new word restarts the gap too
  always @(posedge sys_clk_i) begin
    pd <= dac_code_o;
    pw <= w;
    ph <= hw_power_save_o;
    gap <= (!rstn_i || dac_code_o != pd || w != pw) ? 16'h0000 : gap + 16'h0001;
  end
  property p_off; !power_enable_pin_i [*5] |-> hw_power_save_o && !sink_enable_o && dac_code_o == 10'h000; endproperty
  a_off: assert property (p_off) else $error("live while off");
  property p_mode; sink_enable_o == (!hw_power_save_o && !soft_standby_o); endproperty
  a_mode: assert property (p_mode) else $error("bad sink mode");
  property p_commit; w != pw |-> scl_i && sda_i && $past(scl_i, 4); endproperty
  a_commit: assert property (p_commit) else $error("word not on stop");
  property p_dir; sl |-> (pd < t) ? (dac_code_o > pd && dac_code_o <= t) : (dac_code_o < pd && dac_code_o >= t); endproperty
  a_dir: assert property (p_dir) else $error("slew overshoot");
  property p_step; sl |-> dac_code_o == t || dif == (10'h001 << (w[3:2] - 2'h1)); endproperty
  a_step: assert property (p_step) else $error("bad step size");
  property p_per; sl |-> gap + 16'h0003 >= n && gap <= n; endproperty
  a_per: assert property (p_per) else $error("bad step period");
  property p_ack; $rose(sda_oe_o) |-> !scl_i && !sda_o; endproperty
  a_ack: assert property (p_ack) else $error("drive in clock high");
  property p_imm; w != pw && w[3:2] == 2'h0 && !w[15] && !hw_power_save_o |-> ##[0:2] dac_code_o == t; endproperty
  a_imm: assert property (p_imm) else $error("code not applied");
  c_slew: cover property (sl);
  c_ack: cover property ($rose(sda_oe_o));
  c_off: cover property (hw_power_save_o);
endmodule // vcm_slew_props
bind vcm_slew_core vcm_slew_props vcm_slew_props_inst (.*);

/* File: tb/vcm_i2c_master.sv */
module vcm_i2c_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o = 1'b1,
  output logic      sda_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic q(input int k);
    repeat (2 * k) @(negedge clk_i);
  endtask
  // data moves mid-low so the synced copies see it settled before the rise
  task automatic bx(input logic b, output logic r);
    q(1);
    sda_o = b;
    q(1);
    scl_o = 1'b1;
    q(1);
    r = sda_i;
    q(1);
    scl_o = 1'b0;
  endtask
  task automatic by(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bx(d[i], r[i]);
    bx(m, a);
  endtask
  task automatic go(input logic [7:0] ar, input logic [15:0] wd, output logic [15:0] rd, output logic [2:0] na);
    logic [7:0] t;
    q(1);
    sda_o = 1'b0;
    q(2);
    scl_o = 1'b0;
    by(ar, 1'b1, t, na[2]);
    by(wd[15:8], ~ar[0], rd[15:8], na[1]);
    by(wd[7:0], 1'b1, rd[7:0], na[0]);
    q(1);
    sda_o = 1'b0;
    q(1);
    scl_o = 1'b1;
    q(2);
    sda_o = 1'b1;
    q(2);
  endtask
endmodule // vcm_i2c_master

/* File: tb/vcm_dac_slew_control_tb.sv */
module vcm_dac_slew_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] A = 7'h0C;
  logic        sys_clk_i = 1'b0, rstn_i = 1'b0, power_enable_pin_i = 1'b1, scl_i, sdm, sda_o, sda_oe_o;
  logic        sink_enable_o, hw_power_save_o, soft_standby_o;
  logic [9:0]  dac_code_o;
  logic [15:0] current_control_word_o, rd;
  logic [2:0]  na;
  logic [3:0]  sv [4] = '{4'h4, 4'h8, 4'hC, 4'hD};
  logic [9:0]  e1 [4] = '{10'h001, 10'h002, 10'h004, 10'h000};
  logic [9:0]  e2 [4] = '{10'h002, 10'h004, 10'h008, 10'h004};
  int          num_errors = 0, samples_checked = 0;
  wire logic   sda_i = sdm & ~(sda_oe_o & ~sda_o);
  vcm_slew_core #(.DEV_ADDR(A)) vcm_slew_core_inst (.*);
  vcm_i2c_master vcm_i2c_master_inst (.clk_i(sys_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(sdm));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic xf(input logic [7:0] ar, input logic [15:0] w);
    vcm_i2c_master_inst.go(ar, w, rd, na);
    repeat (10) @(negedge sys_clk_i);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    xf({A, 1'b0}, 16'h8120);
    chk(current_control_word_o, 16'h8120);
    chk({na, soft_standby_o, sink_enable_o}, 5'h02);
    xf({A, 1'b0}, 16'h3FF0);
    chk({soft_standby_o, sink_enable_o, dac_code_o}, {2'b01, 10'h3FF});
    xf({A, 1'b1}, 16'hFFFF);
    chk(rd, 16'h3FF0);
    xf({A ^ 7'h01, 1'b0}, 16'h0000);
    chk({na[2], current_control_word_o[14:0]}, 16'hBFF0);
    power_enable_pin_i = 1'b0;
    xf({A, 1'b0}, 16'h0550);
    chk({hw_power_save_o, sink_enable_o, dac_code_o}, 12'h800);
    chk(current_control_word_o, 16'h3FF0);
    power_enable_pin_i = 1'b1;
    foreach (sv[i]) begin
      xf({A, 1'b0}, 16'h0000);
      xf({A, 1'b0}, {12'h008, sv[i]});
      repeat (3830) @(negedge sys_clk_i);
      chk(dac_code_o, e1[i]);
      repeat (2560) @(negedge sys_clk_i);
      chk(dac_code_o, e2[i]);
    end
    end_of_test();
  end
endmodule // vcm_dac_slew_control_tb
